// ### src/cri_map.vh
// constants for the analyzer storage init and match store key sizing
`ifndef CRI_MAP_VH
`define CRI_MAP_VH

// ==========================================
// key size classes
`define CRI_CLS_X1        3'h0
`define CRI_CLS_X2        3'h1
`define CRI_CLS_X4        3'h2
`define CRI_CLS_X8        3'h3
`define CRI_CLS_X16       3'h4

// ==========================================
// storage words per entry
`define CRI_WORDS_X1      5'h01
`define CRI_WORDS_X2      5'h02
`define CRI_WORDS_X4      5'h04
`define CRI_WORDS_X8      5'h08
`define CRI_WORDS_X16     5'h10

// ==========================================
// key widths in bits, by class and type selector
`define CRI_KW_X1         10'h023
`define CRI_KW_X2_T0      10'h045
`define CRI_KW_X2_T1      10'h044
`define CRI_KW_X2_T2      10'h045
`define CRI_KW_X4_T0      10'h088
`define CRI_KW_X4_T1      10'h081
`define CRI_KW_X4_T2      10'h089
`define CRI_KW_X4_T3      10'h088
`define CRI_KW_X8_T0      10'h110
`define CRI_KW_X8_T1      10'h10A
`define CRI_KW_X8_T2      10'h0FF
`define CRI_KW_X8_T3      10'h110
`define CRI_KW_X16_T0     10'h218
`define CRI_KW_X16_T1     10'h20F
`define CRI_KW_NONE       10'h000

// ==========================================
// type selector field, starting at key bit 0
`define CRI_TYPE_POS      0
`define CRI_TYPE_W_MULTI  2
`define CRI_TYPE_W_X16    1

// ==========================================
// reset values
`define CRI_RST_MEM_EN    1'b0
`define CRI_RST_INIT_BIT  1'b0
`define CRI_RST_READY     1'b0

`endif

// ### src/cri_key_class.v
// decodes the size class and type selector of a match store key
`timescale 1ns/1ns
`include "cri_map.vh"

module cri_key_class #(
	parameter KEY_W = 560
) (
	// key under test
	input  wire [2:0]       ent_class,
	input  wire [KEY_W-1:0] ent_key,
	// decode results
	output wire [4:0]       word_cnt,
	output wire [9:0]       key_width,
	output wire [1:0]       type_sel,
	output wire             legal
);

	// ==========================================
	// lookup functions
	// words per size class
	function [4:0] words_of;
		input [2:0] cls;
		begin
			case (cls)
				`CRI_CLS_X1:  words_of = `CRI_WORDS_X1;
				`CRI_CLS_X2:  words_of = `CRI_WORDS_X2;
				`CRI_CLS_X4:  words_of = `CRI_WORDS_X4;
				`CRI_CLS_X8:  words_of = `CRI_WORDS_X8;
				`CRI_CLS_X16: words_of = `CRI_WORDS_X16;
				default:      words_of = 5'h00;
			endcase
		end
	endfunction

	// width zero marks an unused type code
	function [9:0] width_of;
		input [2:0] cls;
		input [1:0] typ;
		begin
			width_of = `CRI_KW_NONE;
			case (cls)
				`CRI_CLS_X1:  width_of = `CRI_KW_X1;
				`CRI_CLS_X2:
				case (typ)
					2'h0:    width_of = `CRI_KW_X2_T0;
					2'h1:    width_of = `CRI_KW_X2_T1;
					2'h2:    width_of = `CRI_KW_X2_T2;
					default: width_of = `CRI_KW_NONE;
				endcase
				`CRI_CLS_X4:
				case (typ)
					2'h0:    width_of = `CRI_KW_X4_T0;
					2'h1:    width_of = `CRI_KW_X4_T1;
					2'h2:    width_of = `CRI_KW_X4_T2;
					default: width_of = `CRI_KW_X4_T3;
				endcase
				`CRI_CLS_X8:
				case (typ)
					2'h0:    width_of = `CRI_KW_X8_T0;
					2'h1:    width_of = `CRI_KW_X8_T1;
					2'h2:    width_of = `CRI_KW_X8_T2;
					default: width_of = `CRI_KW_X8_T3;
				endcase
				`CRI_CLS_X16:
				width_of = typ[0] ? `CRI_KW_X16_T1 : `CRI_KW_X16_T0;
				default: width_of = `CRI_KW_NONE;
			endcase
		end
	endfunction

	// ==========================================
	// type selector extraction
	// 2-bit selector, 1-bit for sixteen words, none for one word (forced to 0)
	assign type_sel  = (ent_class == `CRI_CLS_X16) ?
	                   {1'b0, ent_key[`CRI_TYPE_POS]} :
	                   ((ent_class == `CRI_CLS_X1) ? 2'h0 :
	                   ent_key[`CRI_TYPE_POS + `CRI_TYPE_W_MULTI - 1:`CRI_TYPE_POS]);
	assign word_cnt  = words_of(ent_class);
	assign key_width = width_of(ent_class, type_sel);

	// bits beyond the key width must be zero, else the entry is refused
	assign legal = (key_width != `CRI_KW_NONE) && ((ent_key >> key_width) == {KEY_W{1'b0}});

endmodule

// ### src/cri_top.v
// analyzer storage start-up init and classification match store entry writer
`timescale 1ns/1ns
`include "cri_map.vh"

module cri_top #(
	parameter DEPTH  = 64,
	parameter ADDR_W = 6,
	parameter WORD_W = 35
) (
	// clock and reset
	input  wire              ref_clk,
	input  wire              rst_b,
	input  wire              clk_en,
	// control bits
	input  wire              mem_enable_in,
	input  wire              init_trigger_wr,
	// status bits
	output reg               memory_enable_bit,
	output reg               init_trigger_bit,
	// entry write port
	input  wire              ent_valid,
	input  wire [ADDR_W-1:0] ent_base,
	input  wire [2:0]        ent_class,
	input  wire [WORD_W*16-1:0] ent_key,
	output reg               ent_ready,
	output reg               ent_err,
	// word read port
	input  wire              rd_en,
	input  wire [ADDR_W-1:0] rd_addr,
	output reg               rd_valid,
	output reg  [WORD_W-1:0] rd_data
);

	localparam KEY_W = WORD_W * 16;
	localparam [31:0]       LAST_I    = DEPTH - 1;
	localparam [31:0]       DEPTH_I   = DEPTH;
	localparam [ADDR_W-1:0] LAST_ADDR = LAST_I[ADDR_W-1:0];
	localparam [ADDR_W:0]   DEPTH_N   = DEPTH_I[ADDR_W:0];
	localparam [1:0] ST_IDLE  = 2'h0;
	localparam [1:0] ST_INIT  = 2'h1;
	localparam [1:0] ST_WRITE = 2'h2;

	// ==========================================
	// reset synchroniser
	reg rst_meta_q;
	reg rst_sync_q;

	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// ==========================================
	// key decode
	wire [4:0] word_cnt;
	wire [9:0] key_width;
	wire [1:0] type_sel;
	wire       key_legal;

	// key is taken with its first field at bit 0
	cri_key_class #(
		.KEY_W (KEY_W)
	) u_cls (
		.ent_class (ent_class),
		.ent_key   (ent_key),
		.word_cnt  (word_cnt),
		.key_width (key_width),
		.type_sel  (type_sel),
		.legal     (key_legal)
	);

	// entry must be aligned to its size and fit the store
	function placed_ok;
		input [ADDR_W-1:0] base;
		input [4:0]        cnt;
		reg   [4:0]        cnt_m1;
		reg   [ADDR_W:0]   end_a;
		begin
			cnt_m1    = cnt - 5'h01;
			end_a     = {1'b0, base} + {{(ADDR_W-4){1'b0}}, cnt};
			placed_ok = (cnt != 5'h00) && ((base[3:0] & cnt_m1[3:0]) == 4'h0) &&
			            (end_a <= DEPTH_N);
		end
	endfunction

	// ==========================================
	// state
	reg [1:0]        st_q;
	reg [1:0]        st_d;
	reg [ADDR_W-1:0] addr_q;
	reg [4:0]        left_q;
	reg [KEY_W-1:0]  key_q;
	reg [WORD_W-1:0] store_mem [0:DEPTH-1];

	// init only starts while the memory is enabled
	wire init_go = init_trigger_wr & mem_enable_in;
	wire take    = (st_q == ST_IDLE) & ent_ready & ent_valid & ~init_go;
	wire ent_ok  = key_legal & placed_ok(ent_base, word_cnt);

	always @*
	begin
		st_d = st_q;
		case (st_q)
			ST_IDLE:
			begin
				if (init_go)
					st_d = ST_INIT;
				else if (take & ent_ok)
					st_d = ST_WRITE;
			end
			ST_INIT:
			begin
				// a new trigger restarts the sweep, so the set wins over the clear
				if (!init_go && addr_q == LAST_ADDR)
					st_d = ST_IDLE;
			end
			ST_WRITE:
			begin
				if (init_go)
					st_d = ST_INIT;
				else if (left_q == 5'h01)
					st_d = ST_IDLE;
			end
			default: st_d = ST_IDLE;
		endcase
	end

	// ==========================================
	// control registers
	always @(posedge ref_clk or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			st_q   <= ST_IDLE;
			addr_q <= {ADDR_W{1'b0}};
			left_q <= 5'h00;
			key_q  <= {KEY_W{1'b0}};
		end
		else if (clk_en)
		begin
			st_q <= st_d;
			if (init_go)
				addr_q <= {ADDR_W{1'b0}};
			else if (take & ent_ok)
			begin
				addr_q <= ent_base;
				left_q <= word_cnt;
				key_q  <= ent_key;
			end
			else if (st_q == ST_INIT || st_q == ST_WRITE)
			begin
				addr_q <= addr_q + {{(ADDR_W-1){1'b0}}, 1'b1};
				// word slices leave low first, so bit 0 lands in the base word
				key_q  <= key_q >> WORD_W;
				left_q <= left_q - {4'h0, (st_q == ST_WRITE)};
			end
		end
	end

	// ==========================================
	// status bits
	// sweep end is taken from the next state so ready rises as the init bit falls
	wire sweep_end = (st_q == ST_INIT) & (st_d == ST_IDLE);

	always @(posedge ref_clk or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			memory_enable_bit <= `CRI_RST_MEM_EN;
			init_trigger_bit  <= `CRI_RST_INIT_BIT;
			ent_ready         <= `CRI_RST_READY;
			ent_err           <= 1'b0;
		end
		else if (clk_en)
		begin
			memory_enable_bit <= mem_enable_in;
			ent_err           <= take & ~ent_ok;
			// init bit drops when the sweep ends
			if (init_go)
				init_trigger_bit <= 1'b1;
			else if (sweep_end)
				init_trigger_bit <= 1'b0;
			// entries only accepted after init clears
			ent_ready <= (st_d == ST_IDLE) & mem_enable_in & ~init_go &
			             ~(init_trigger_bit & ~sweep_end);
		end
	end

	// ==========================================
	// read port
	// a read of a word being written returns the old data
	always @(posedge ref_clk or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			rd_valid <= 1'b0;
			rd_data  <= {WORD_W{1'b0}};
		end
		else if (clk_en)
		begin
			rd_valid <= rd_en;
			if (rd_en)
				rd_data <= store_mem[rd_addr];
		end
	end

	// ==========================================
	// storage array
	// no reset here: the init sweep is what clears it, one word a cycle
	wire mem_we = clk_en & rst_sync_q & ~init_go & ((st_q == ST_INIT) | (st_q == ST_WRITE));

	always @(posedge ref_clk)
	begin
		if (mem_we)
			store_mem[addr_q] <= (st_q == ST_INIT) ? {WORD_W{1'b0}} : key_q[WORD_W-1:0];
	end

endmodule

// ### verification/cri_top_chk.sv
// checker for init sweep timing and entry refusal at the top ports
`timescale 1ns/1ns
module cri_chk #(parameter DEPTH = 64, ADDR_W = 6, WORD_W = 35) (
	input wire                ref_clk, rst_b, clk_en, mem_enable_in, init_trigger_wr,
	input wire                memory_enable_bit, init_trigger_bit, ent_valid, ent_ready,
	input wire                ent_err, rd_en, rd_valid,
	input wire [ADDR_W-1:0]   ent_base, rd_addr,
	input wire [2:0]          ent_class,
	input wire [WORD_W*16-1:0] ent_key,
	input wire [WORD_W-1:0]   rd_data
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	wire       trig = clk_en && init_trigger_wr && mem_enable_in;
	wire       tk   = clk_en && ent_valid && ent_ready && !trig;
	reg [15:0] cnt_q;
	// sweep position; a new trigger restarts it, so set wins over clear
	always @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
			cnt_q <= 16'h0000;
		else if (trig)
			cnt_q <= 16'h0001;
		else if (clk_en && cnt_q != 16'h0000)
			cnt_q <= (cnt_q == 16'(DEPTH)) ? 16'h0000 : cnt_q + 16'h0001;
	sequence s_x1;
		tk && ent_class == 3'h0 && (ent_key >> 35) == 0 && ent_base < DEPTH;
	endsequence
	sequence s_wr1;
		!ent_ready && !ent_err ##1 ent_ready;
	endsequence
	AST_INIT_SET:
		assert property (trig |=> init_trigger_bit) else $error("init bit not set");
	AST_INIT_LEN:
		assert property (init_trigger_bit == (cnt_q != 0)) else $error("init length wrong");
	AST_INIT_BLOCK:
		assert property (init_trigger_bit |-> !ent_ready) else $error("ready during init");
	AST_EN_BLOCK:
		assert property (!mem_enable_in [*3] |-> !ent_ready) else $error("ready while off");
	AST_BAD_CLASS:
		assert property (tk && ent_class > 3'h4 |=> ent_err) else $error("bad class taken");
	AST_ALIGN:
		assert property (tk && ent_class == 3'h1 && ent_base[0] |=> ent_err)
			else $error("odd base taken");
	AST_X2_WIDTH:
		assert property (tk && ent_class == 3'h1 && ent_key[1:0] == 2'h1 && ent_key[68]
			|=> ent_err) else $error("wide key taken");
	AST_X2_TYPE:
		assert property (tk && ent_class == 3'h1 && ent_key[1:0] == 2'h3 |=> ent_err)
			else $error("unused type taken");
	AST_X1_OK:
		assert property (s_x1 |=> s_wr1) else $error("single word write timing");
	AST_RD:
		assert property (rd_en && clk_en |=> rd_valid) else $error("read not answered");
	AST_FREEZE:
		assert property (!clk_en |=> $stable(init_trigger_bit) && $stable(ent_ready))
			else $error("state moved while frozen");
endmodule

bind cri_top cri_chk #(.DEPTH(DEPTH), .ADDR_W(ADDR_W), .WORD_W(WORD_W)) u_cri_chk (
	.ref_clk, .rst_b, .clk_en, .mem_enable_in, .init_trigger_wr, .memory_enable_bit,
	.init_trigger_bit, .ent_valid, .ent_ready, .ent_err, .rd_en, .rd_valid, .ent_base,
	.rd_addr, .ent_class, .ent_key, .rd_data);

// ### verification/cri_top_tb.sv
// self-checking bench for init sweep and entry writes
`timescale 1ns/1ns
module cri_top_tb;
	localparam D = 32;
	reg         ref_clk = 0, rst_b = 0, clk_en = 1, mem_en = 0, init_wr = 0;
	reg         ent_valid = 0, rd_en = 0;
	reg [4:0]   ent_base = 0, rd_addr = 0;
	reg [2:0]   ent_class = 0;
	reg [559:0] ent_key = 0;
	wire        meb, itb, ent_ready, ent_err, rd_valid;
	wire [34:0] rd_data;
	integer     fails = 0, checked = 0, cyc = 0;
	cri_top #(.DEPTH(D), .ADDR_W(5)) u_cri_top (.ref_clk, .rst_b, .clk_en,
		.mem_enable_in(mem_en), .init_trigger_wr(init_wr), .memory_enable_bit(meb),
		.init_trigger_bit(itb), .ent_valid, .ent_base, .ent_class, .ent_key, .ent_ready,
		.ent_err, .rd_en, .rd_addr, .rd_valid, .rd_data);
	always #5 ref_clk = ~ref_clk;
	task chk(input bit ok, input string m);
		checked++;
		if (!ok)
		begin
			fails++;
			$display("FAIL %0t %s", $time, m);
		end
	endtask
	task print_verdict;
		if (fails == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// the whole run needs well under a thousand cycles
	always @(posedge ref_clk)
		if (++cyc == 5000)
		begin
			fails++;
			print_verdict;
		end
	task rd(input [4:0] a, input [34:0] e);
		@(posedge ref_clk) rd_en <= 1;
		rd_addr <= a;
		@(posedge ref_clk) rd_en <= 0;
		@(negedge ref_clk) chk(rd_valid === 1'b1 && rd_data === e, "read data");
	endtask
	task init_run;
		integer n;
		n = 0;
		@(posedge ref_clk) init_wr <= 1;
		@(posedge ref_clk) init_wr <= 0;
		@(negedge ref_clk);
		while (itb === 1'b1 && n < 200)
		begin
			n++;
			@(negedge ref_clk);
		end
		chk(n == D && ent_ready === 1'b1 && meb === 1'b1, "init sweep");
	endtask
	task entry(input [2:0] c, input [4:0] b, input [559:0] k, input bit err);
		integer i;
		@(negedge ref_clk);
		while (ent_ready !== 1'b1) @(negedge ref_clk);
		@(posedge ref_clk) ent_valid <= 1;
		ent_class <= c;
		ent_base <= b;
		ent_key <= k;
		@(posedge ref_clk) ent_valid <= 0;
		@(negedge ref_clk) chk(ent_err === err, "entry refusal");
		// let the write finish, a read of a word in flight returns old data
		while (ent_ready !== 1'b1) @(negedge ref_clk);
		if (!err)
			for (i = 0; i < (1 << c); i++)
				rd(b + i[4:0], k[i*35 +: 35]);
	endtask
	task t_enable;
		@(posedge ref_clk) init_wr <= 1;
		@(posedge ref_clk) init_wr <= 0;
		@(negedge ref_clk) chk(itb === 1'b0, "trigger while off");
		@(posedge ref_clk) mem_en <= 1;
		init_run;
	endtask
	task t_keys;
		entry(3'h0, 5'h03, (560'h1 << 34) | 560'h5, 0);
		entry(3'h0, 5'h02, 560'h1 << 35, 1);
		entry(3'h1, 5'h04, (560'h1 << 67) | 560'h1, 0);
		entry(3'h1, 5'h04, (560'h1 << 68) | 560'h1, 1);
		entry(3'h1, 5'h06, 560'h3, 1);
		entry(3'h1, 5'h05, 560'h0, 1);
		entry(3'h2, 5'h08, (560'h1 << 136) | 560'h2, 0);
		entry(3'h3, 5'h10, (560'h1 << 265) | 560'h1, 0);
		entry(3'h3, 5'h10, (560'h1 << 255) | 560'h2, 1);
		entry(3'h4, 5'h00, (560'h1 << 526) | 560'h1, 0);
		entry(3'h4, 5'h08, 560'h0, 1);
		entry(3'h5, 5'h00, 560'h0, 1);
		entry(3'h1, 5'h04, 560'h1 << 68, 0);
		entry(3'h1, 5'h02, (560'h1 << 68) | 560'h2, 0);
		entry(3'h2, 5'h08, (560'h1 << 129) | 560'h1, 1);
		entry(3'h2, 5'h0C, (560'h1 << 135) | 560'h3, 0);
		entry(3'h3, 5'h18, 560'h1 << 271, 0);
		entry(3'h4, 5'h10, 560'h1 << 536, 1);
		entry(3'h4, 5'h10, 560'h1 << 535, 0);
	endtask
	task t_reinit;
		init_run;
		rd(5'h00, 35'h0);
	endtask
	// five frozen cycles must stretch the sweep by exactly five
	task t_freeze;
		integer n;
		n = 0;
		@(posedge ref_clk) init_wr <= 1;
		@(posedge ref_clk) init_wr <= 0;
		clk_en <= 0;
		repeat (5) @(posedge ref_clk);
		clk_en <= 1;
		@(negedge ref_clk);
		while (itb === 1'b1 && n < 200)
		begin
			n++;
			@(negedge ref_clk);
		end
		chk(n == D && ent_ready === 1'b1, "sweep while frozen");
	endtask
	initial
	begin
		repeat (12) @(posedge ref_clk);
		rst_b <= 1;
		repeat (3) @(posedge ref_clk);
		t_enable;
		t_keys;
		t_reinit;
		t_freeze;
		print_verdict;
	end
endmodule
